// >>> rtl/pei_pkg.sv
// Purpose: shared constants and types of the proximity event interrupt logic
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: all offsets are byte addresses
package pei_pkg;

  // ****************************************
  // bus geometry and responses
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_IRQ_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE_A = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MODE_B = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FLAG_CLEAR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PROX1_LIMIT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PROX2_LIMIT = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_HYSTERESIS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PERSISTENCE = 8'h24;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int PIN_OE_BIT = 0;
  localparam int CLR_MODE_BIT = 1;
  localparam int PROX1_MASK_POS = 2;
  localparam int PROX1_MODE_LSB = 4;
  localparam int MODE_W = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] FLAG_IMPL = 8'h0c;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PEI_MODE_EVERY = 2'b00,
    PEI_MODE_CROSS = 2'b01,
    PEI_MODE_NONE = 2'b10,
    PEI_MODE_ABOVE = 2'b11
  } pei_mode_e;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } pei_sample_s;

endpackage : pei_pkg

// >>> rtl/pei_top.sv
// Purpose: event flags, masking and interrupt pin of the proximity channels
// Assumes: sequencer delivers one-cycle sample strobes with 8-bit compressed codes
// Notes: register access over AXI4-Lite, 32-bit data, byte lane 0 only
//
// Notes on behaviour
// - interrupt pin drives only while pin-enable bit 0 of irq config is set
// - pin asserts when any bit of mask AND flags is one
// - writing one clears that flag bit, writing zero leaves it
// - prox1 mask bit 2, mode bits 5:4; mode 00 flags every sample
// - prox1 mode 01 flags each threshold crossing
// - prox1 mode 11 flags each sample above threshold
// - prox1 mask clear never sets its flag
// - prox2 mask bit 3, mode bits 7:6; mode 00 flags every sample
// - prox2 mode 01 flags each threshold crossing
// - prox2 mode 11 flags each sample above threshold
// - threshold compare uses shared hysteresis and persistence, 8-bit codes
`timescale 1ns/1ps
module pei_top
  import pei_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire pei_sample_s prox1_sample_in,
  input wire pei_sample_s prox2_sample_in,
  output logic [NUM_CH-1:0] prox_above_out,
  output logic irq_out
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] irq_config;
  logic [7:0] event_mask;
  logic [7:0] event_mode_reg_a;
  logic [7:0] event_mode_reg_b;
  logic [7:0] event_flags;
  logic [7:0] prox1_limit;
  logic [7:0] prox2_limit;
  logic [7:0] prox_hysteresis;
  logic [7:0] prox_persistence;

  logic aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic w_held;
  logic [7:0] w_byte;
  logic w_lane0;
  logic wr_fire;
  logic wr_hit;
  logic clr_hit;
  logic [7:0] clr_vec;
  logic [7:0] set_vec;
  logic [7:0] next_flags;
  logic ar_fire;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [NUM_CH-1:0] above;
  pei_sample_s smp [NUM_CH];
  logic [7:0] limit [NUM_CH];

  assign smp[0] = prox1_sample_in;
  assign smp[1] = prox2_sample_in;
  assign limit[0] = prox1_limit;
  assign limit[1] = prox2_limit;
  assign prox_above_out = above;

  // ****************************************
  // write channels
  // ****************************************
  // address and data are parked separately so either may arrive first
  assign s_axi_awready_out = !aw_held;
  assign s_axi_wready_out = !w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_in && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      w_held <= 1'b0;
      w_byte <= RST_BYTE;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid_in && !w_held) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata_in[7:0];
      w_lane0 <= s_axi_wstrb_in[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    unique case (aw_addr)
      OFS_IRQ_CONFIG, OFS_EVENT_MASK, OFS_MODE_A, OFS_MODE_B, OFS_EVENT_FLAGS,
      OFS_FLAG_CLEAR, OFS_PROX1_LIMIT, OFS_PROX2_LIMIT, OFS_HYSTERESIS,
      OFS_PERSISTENCE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_config <= RST_BYTE;
      event_mask <= RST_BYTE;
      event_mode_reg_a <= RST_BYTE;
      event_mode_reg_b <= RST_BYTE;
      prox1_limit <= RST_BYTE;
      prox2_limit <= RST_BYTE;
      prox_hysteresis <= RST_BYTE;
      prox_persistence <= RST_BYTE;
    end else if (wr_fire && w_lane0) begin
      unique case (aw_addr)
        OFS_IRQ_CONFIG: irq_config <= w_byte;
        OFS_EVENT_MASK: event_mask <= w_byte;
        OFS_MODE_A: event_mode_reg_a <= w_byte;
        OFS_MODE_B: event_mode_reg_b <= w_byte;
        OFS_PROX1_LIMIT: prox1_limit <= w_byte;
        OFS_PROX2_LIMIT: prox2_limit <= w_byte;
        OFS_HYSTERESIS: prox_hysteresis <= w_byte;
        OFS_PERSISTENCE: prox_persistence <= w_byte;
        default: ;
      endcase
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr_in)
      OFS_IRQ_CONFIG: rd_byte = irq_config;
      OFS_EVENT_MASK: rd_byte = event_mask;
      OFS_MODE_A: rd_byte = event_mode_reg_a;
      OFS_MODE_B: rd_byte = event_mode_reg_b;
      OFS_EVENT_FLAGS: rd_byte = event_flags;
      OFS_FLAG_CLEAR: rd_byte = RST_BYTE;
      OFS_PROX1_LIMIT: rd_byte = prox1_limit;
      OFS_PROX2_LIMIT: rd_byte = prox2_limit;
      OFS_HYSTERESIS: rd_byte = prox_hysteresis;
      OFS_PERSISTENCE: rd_byte = prox_persistence;
      default: begin
        rd_byte = RST_BYTE;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {24'h000000, rd_byte};
      s_axi_rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ****************************************
  // per-channel threshold and event logic
  // ****************************************
  assign set_vec[PROX1_MASK_POS-1:0] = '0;
  assign set_vec[7:PROX1_MASK_POS+NUM_CH] = '0;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [8:0] up_sum;
    logic [7:0] up_lim;
    logic [7:0] dn_lim;
    logic wants_flip;
    logic flip;
    logic mask_bit;
    logic [7:0] run;
    pei_mode_e mode;
    logic ev;

    assign mask_bit = event_mask[PROX1_MASK_POS+ch];
    assign mode = pei_mode_e'(event_mode_reg_a[PROX1_MODE_LSB+MODE_W*ch +: MODE_W]);
    // band edges saturate so a large hysteresis cannot wrap around the code range
    assign up_sum = {1'b0, limit[ch]} + {1'b0, prox_hysteresis};
    assign up_lim = up_sum[8] ? 8'hff : up_sum[7:0];
    assign dn_lim = (limit[ch] > prox_hysteresis) ? limit[ch] - prox_hysteresis : 8'h00;
    assign wants_flip = above[ch] ? (smp[ch].code <= dn_lim) : (smp[ch].code > up_lim);
    // side changes only after persistence earlier samples agreed
    assign flip = smp[ch].valid && wants_flip && (run >= prox_persistence);

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
        run <= 8'h00;
      end else if (smp[ch].valid) begin
        if (wants_flip && !flip && run != 8'hff) begin
          run <= run + 8'h01;
        end else if (!wants_flip || flip) begin
          run <= 8'h00;
        end
      end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
        above[ch] <= 1'b0;
      end else if (flip) begin
        above[ch] <= !above[ch];
      end
    end

    always_comb begin
      ev = 1'b0;
      if (smp[ch].valid && mask_bit) begin
        unique case (mode)
          PEI_MODE_EVERY: ev = 1'b1;
          PEI_MODE_CROSS: ev = flip;
          PEI_MODE_ABOVE: ev = above[ch] ^ flip;
          PEI_MODE_NONE: ev = 1'b0;
        endcase
      end
    end
    assign set_vec[PROX1_MASK_POS+ch] = ev;

    every_sample_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      smp[ch].valid && mask_bit && mode == PEI_MODE_EVERY |=> event_flags[PROX1_MASK_POS+ch])
      else $error("flag missing after sample in every-sample mode");
    masked_never_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      $rose(event_flags[PROX1_MASK_POS+ch]) |-> $past(mask_bit) && $past(smp[ch].valid))
      else $error("flag set while channel masked or without sample");
    cross_only_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      $rose(event_flags[PROX1_MASK_POS+ch]) && $past(mode) == PEI_MODE_CROSS
      |-> $past(above[ch]) != above[ch])
      else $error("crossing flag set without a side change");
    above_mode_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      smp[ch].valid && mask_bit && mode == PEI_MODE_ABOVE && above[ch]
      && smp[ch].code > dn_lim |=> event_flags[PROX1_MASK_POS+ch])
      else $error("above-threshold sample did not set flag");
    mode_ten_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      mode == PEI_MODE_NONE && !event_flags[PROX1_MASK_POS+ch]
      |=> !event_flags[PROX1_MASK_POS+ch])
      else $error("mode 10 produced a flag");
    side_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      !smp[ch].valid |=> $stable(above[ch]))
      else $error("threshold side changed without a sample");
  end

  // ****************************************
  // sticky flags and interrupt pin
  // ****************************************
  // clear and status offsets both clear by writing ones
  assign clr_hit = wr_fire && w_lane0 && (aw_addr == OFS_EVENT_FLAGS || aw_addr == OFS_FLAG_CLEAR);
  assign clr_vec = clr_hit ? w_byte : 8'h00;
  // a new event in the clearing cycle survives the clear
  assign next_flags = ((event_flags & ~clr_vec) | set_vec) & FLAG_IMPL;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      event_flags <= RST_BYTE;
    end else begin
      event_flags <= next_flags;
    end
  end

  assign irq_out = irq_config[PIN_OE_BIT] && |(event_mask & event_flags);

  pin_gate_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !irq_config[PIN_OE_BIT] |-> !irq_out)
    else $error("interrupt pin active while pin disabled");
  pin_and_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    irq_config[PIN_OE_BIT] && (event_mask[3:2] & event_flags[3:2]) != 2'b00 |-> irq_out)
    else $error("enabled pending flag did not raise the pin");
  clear_one_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    clr_hit && w_byte[2] && !set_vec[2] |=> !event_flags[2])
    else $error("writing one did not clear the flag");
  flag_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    event_flags[3] && !(clr_hit && w_byte[3]) |=> event_flags[3])
    else $error("flag dropped without a clearing write");
  write_resp_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    wr_fire |=> s_axi_bvalid_out && !aw_held && !w_held)
    else $error("write not answered one cycle after both parts held");

endmodule : pei_top

// >>> verif/pei_host_model.sv
// Purpose: host processor model, AXI4-Lite master that services the event flags
// Assumes: one transfer at a time, ready and valid sampled between clock edges
// Notes: hang_out rises when an answer never comes, so the bench can stop
`timescale 1ns/1ps
module pei_host_model
  import pei_pkg::*;
(
  input wire logic clk_in,
  input wire logic awready_in,
  input wire logic wready_in,
  input wire logic bvalid_in,
  input wire logic arready_in,
  input wire logic rvalid_in,
  input wire logic [DATA_W-1:0] rdata_in,
  output logic awvalid_out,
  output logic [ADDR_W-1:0] awaddr_out,
  output logic wvalid_out,
  output logic [DATA_W-1:0] wdata_out,
  output logic bready_out,
  output logic arvalid_out,
  output logic [ADDR_W-1:0] araddr_out,
  output logic rready_out,
  output logic hang_out
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out, hang_out} = '0;
    {awaddr_out, araddr_out, wdata_out} = '0;
  end

  // an edge passes first so no strobe is assigned twice in one time step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic ha, hw, hb;
    int n;
    @(posedge clk_in);
    awvalid_out <= 1'b1;
    awaddr_out <= a;
    wvalid_out <= 1'b1;
    wdata_out <= d;
    bready_out <= 1'b1;
    n = 0;
    hb = 1'b0;
    while (!hb && n < 300) begin
      @(negedge clk_in);
      ha = awvalid_out && awready_in;
      hw = wvalid_out && wready_in;
      hb = bvalid_in && bready_out;
      @(posedge clk_in);
      if (ha) awvalid_out <= 1'b0;
      if (hw) wvalid_out <= 1'b0;
      if (hb) bready_out <= 1'b0;
      n++;
    end
    if (!hb) hang_out <= 1'b1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    logic ha, hr;
    int n;
    @(posedge clk_in);
    arvalid_out <= 1'b1;
    araddr_out <= a;
    rready_out <= 1'b1;
    n = 0;
    hr = 1'b0;
    d = '0;
    while (!hr && n < 300) begin
      @(negedge clk_in);
      ha = arvalid_out && arready_in;
      hr = rvalid_in && rready_out;
      d = rdata_in;
      @(posedge clk_in);
      if (ha) arvalid_out <= 1'b0;
      if (hr) rready_out <= 1'b0;
      n++;
    end
    if (!hr) hang_out <= 1'b1;
  endtask : rd

  // clear mode zero, pin driven: the usual setting
  task automatic normal_cfg();
    wr(OFS_IRQ_CONFIG, 32'h1);
  endtask : normal_cfg

  // keep a copy of the pending flags and hand it back to clear exactly those
  task automatic service();
    logic [DATA_W-1:0] copy;
    rd(OFS_EVENT_FLAGS, copy);
    wr(OFS_EVENT_FLAGS, copy);
  endtask : service
endmodule : pei_host_model

// >>> verif/pei_top_tb_top.sv
// Purpose: self-checking bench of the proximity event interrupt logic
// Assumes: bus results are noted in queues and checked by a watcher process
// Notes: sample codes of the every-sample case come from an lfsr
`timescale 1ns/1ps
module pei_top_tb_top
  import pei_pkg::*;
();
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, hang, irq;
  logic [ADDR_W-1:0] awa, ara;
  logic [DATA_W-1:0] wd, rdat;
  logic [1:0] bresp, rresp, above;
  pei_sample_s s1, s2;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int failures = 0;
  int compares = 0;
  logic [31:0] seed = 32'd86353;

  always #25 clk = ~clk;

  pei_top i_dut (.clk_sys_in(clk), .nrst_in(rst_n), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_awprot_in(3'h0),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'h1), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ara), .s_axi_arprot_in(3'h0), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp),
    .prox1_sample_in(s1), .prox2_sample_in(s2), .prox_above_out(above), .irq_out(irq));

  pei_host_model i_host (.clk_in(clk), .awready_in(awr), .wready_in(wrdy), .bvalid_in(bv),
    .arready_in(arr), .rvalid_in(rv), .rdata_in(rdat), .awvalid_out(awv), .awaddr_out(awa),
    .wvalid_out(wv), .wdata_out(wd), .bready_out(br), .arvalid_out(arv),
    .araddr_out(ara), .rready_out(rr), .hang_out(hang));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic rdx(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
    logic [DATA_W-1:0] d;
    rq.push_back({r, 24'h0, e});
    i_host.rd(a, d);
  endtask : rdx

  task automatic wrx(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    i_host.wr(a, {24'h0, v});
  endtask : wrx

  task automatic svc(input logic [7:0] e);
    rq.push_back({RESP_OKAY, 24'h0, e});
    bq.push_back(RESP_OKAY);
    i_host.service();
  endtask : svc

  // both channels see the same code, so each flag bit is checked at once
  task automatic pulse(input logic [7:0] c);
    s1 <= '{valid: 1'b1, code: c};
    s2 <= '{valid: 1'b1, code: c};
    @(posedge clk);
    s1.valid <= 1'b0;
    s2.valid <= 1'b0;
    @(posedge clk);
  endtask : pulse

  task automatic irq_is(input logic e);
    @(negedge clk);
    chk({33'h0, irq}, {33'h0, e});
    @(posedge clk);
  endtask : irq_is

  // ****************************************
  // watcher and main sequence
  // ****************************************
  always @(posedge clk) begin
    if (rv && rr) chk({rresp, rdat}, rq.pop_front());
    if (bv && br) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (hang) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    s1 = '0;
    s2 = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    irq_is(1'b0);
    rdx(OFS_IRQ_CONFIG, 8'h00);
    rdx(OFS_EVENT_FLAGS, 8'h00);
    rdx(8'h28, 8'h00, RESP_SLVERR);
    wrx(8'h2c, 8'h55, RESP_SLVERR);
    bq.push_back(RESP_OKAY);
    i_host.normal_cfg();
    wrx(OFS_EVENT_MASK, 8'h0c);
    wrx(OFS_MODE_A, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      pulse(seed[7:0]);
      irq_is(1'b1);
      rdx(OFS_EVENT_FLAGS, 8'h0c);
      svc(8'h0c);
      irq_is(1'b0);
    end
    pulse(8'h10);
    wrx(OFS_FLAG_CLEAR, 8'h04);
    rdx(OFS_EVENT_FLAGS, 8'h08);
    wrx(OFS_IRQ_CONFIG, 8'h00);
    irq_is(1'b0);
    wrx(OFS_IRQ_CONFIG, 8'h01);
    wrx(OFS_EVENT_MASK, 8'h04);
    irq_is(1'b0);
    wrx(OFS_EVENT_MASK, 8'h00);
    svc(8'h08);
    for (int m = 0; m < 4; m++) begin
      wrx(OFS_MODE_A, {m[1:0], m[1:0], 4'h0});
      pulse(8'hff);
      rdx(OFS_EVENT_FLAGS, 8'h00);
    end
    wrx(OFS_PROX1_LIMIT, 8'h80);
    wrx(OFS_PROX2_LIMIT, 8'h80);
    wrx(OFS_EVENT_MASK, 8'h0c);
    wrx(OFS_MODE_A, 8'haa);
    pulse(8'h40);
    rdx(OFS_EVENT_FLAGS, 8'h00);
    wrx(OFS_MODE_A, 8'hf0);
    pulse(8'h40);
    rdx(OFS_EVENT_FLAGS, 8'h00);
    repeat (2) begin
      pulse(8'h90);
      chk({32'h0, above}, {32'h0, 2'b11});
      rdx(OFS_EVENT_FLAGS, 8'h0c);
      svc(8'h0c);
    end
    wrx(OFS_HYSTERESIS, 8'h10);
    wrx(OFS_MODE_A, 8'h50);
    pulse(8'h71);
    rdx(OFS_EVENT_FLAGS, 8'h00);
    pulse(8'h70);
    rdx(OFS_EVENT_FLAGS, 8'h0c);
    svc(8'h0c);
    pulse(8'h90);
    rdx(OFS_EVENT_FLAGS, 8'h00);
    wrx(OFS_PERSISTENCE, 8'h02);
    repeat (2) pulse(8'h91);
    rdx(OFS_EVENT_FLAGS, 8'h00);
    pulse(8'h91);
    rdx(OFS_EVENT_FLAGS, 8'h0c);
    svc(8'h0c);
    // channels split apart so a swapped mask bit or mode field shows up
    wrx(OFS_EVENT_MASK, 8'h04);
    wrx(OFS_MODE_A, 8'h00);
    pulse(8'h91);
    svc(8'h04);
    wrx(OFS_EVENT_MASK, 8'h0c);
    wrx(OFS_MODE_A, 8'h20);
    pulse(8'h91);
    rdx(OFS_EVENT_FLAGS, 8'h08);
    tally_and_finish();
  end
endmodule : pei_top_tb_top
